/* File: program_replace_file_status.sv */
// File memory status, self-addressed command gating and program replacement sequencer
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
`include "program_replace_regs.svh"

// How it works
// - Report card type or absence, three bits
// - Extended bank format error set, cleared on success
// - Flag unformatted card or failed card format
// - Flag errors while writing a file
// - Flag write-protect or insufficient free memory
// - Flag corrupt or wrong-type file read
// - Flag read of non-existent file
// - Busy during any file operation or replacement
// - Access flag only while data moves
// - Card-detected flag follows card presence
// - 32-bit remaining count, decremented per item
// - Refuse self command when busy, flag error
// - Start bit rise replaces program at scan end
// - Finish current scan before replacement starts
// - Replace only when every precondition holds
// - Stop execution and watchdog during replacement
// - IOM hold keeps memory, timer values cleared
// - Forced hold keeps force-set and force-reset states
// - Mask interrupts, stop trace, reinit conditions
// - Restart tasks, first-scan flag one scan
// - Start bit clears on finish and reset
// - Failure sets error flag and completion code
module program_replace_file_status
  import program_replace_pkg::*;
#(
  parameter int CARD_TYPE_W = 3,
  parameter int COUNT_W = 32
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CARD_TYPE_W-1:0] cardType,
  input wire logic cardPresent,
  input wire file_events_s fileEvents,
  input wire file_ops_s opStart,
  input wire file_ops_s opDone,
  input wire logic selfCmdReq,
  input wire logic dataAccess,
  input wire logic itemDone,
  input wire logic scanEnd,
  input wire repl_cond_s replCond,
  output logic selfCmdAccept,
  output logic instrErr,
  output logic execHalt,
  output logic watchdogSuspend,
  output logic intMask,
  output logic traceStop,
  output logic condReinit,
  output logic edgeFlagReinit,
  output logic timerPvClear,
  output logic ioMemClear,
  output logic forceClear,
  output logic loadReq,
  output logic tasksRestart,
  output logic firstScan
);
  // Elaboration stops on any card type width other than 3 or count width other than 32
  if (CARD_TYPE_W != 3) begin
    $error("Card type field is three bits");
  end
  if (COUNT_W != 32) begin
    $error("Transfer count is 32 bits");
  end

  repl_state_e state;
  file_ops_s opActive;
  logic [CARD_TYPE_W-1:0] cardTypeReg;
  logic cardDetected, accessing;
  logic emFmtErr, cardFmtErr, writeErr, writeImp, readErr, noFile;
  logic [COUNT_W-1:0] itemsLeft;
  logic startBit, startPrev, ioMemoryKeepBit, forceHoldBit;
  logic [15:0] password;
  logic [63:0] fileName;
  logic replError;
  logic [7:0] replCode;
  logic [7:0] loadCnt;
  logic firstScanPend;
  logic busy, replActive, startRise, selfOk;
  logic wrEn, rdEn;
  logic [7:0] failCode;
  logic [31:0] next_prdata;

  assign replActive = (state != REPL_IDLE);
  assign busy = (|opActive) || replActive;
  assign startRise = startBit && !startPrev;
  assign selfOk = selfCmdReq && !busy;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;

  // Status inputs sampled each clock
  // An absent card reads as type zero; access shows only inside an operation or a replacement
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cardTypeReg <= '0;
      cardDetected <= 1'b0;
      accessing <= 1'b0;
    end else begin
      cardTypeReg <= cardPresent ? cardType : '0;
      cardDetected <= cardPresent;
      accessing <= dataAccess && busy;
    end
  end

  // Error flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      emFmtErr <= 1'b0;
      cardFmtErr <= 1'b0;
      writeErr <= 1'b0;
      writeImp <= 1'b0;
      readErr <= 1'b0;
      noFile <= 1'b0;
    end else begin
      if (fileEvents.emFormatErr) emFmtErr <= 1'b1;
      else if (fileEvents.emFormatDone) emFmtErr <= 1'b0;
      if (fileEvents.cardFormatErr) cardFmtErr <= 1'b1;
      else if (wrEn && paddr == `OFS_FILE_STATUS && pwdata[`FS_CARD_FMT_ERR]) cardFmtErr <= 1'b0;
      if (fileEvents.writeErr) writeErr <= 1'b1;
      else if (wrEn && paddr == `OFS_FILE_STATUS && pwdata[`FS_WRITE_ERR]) writeErr <= 1'b0;
      if (fileEvents.writeImpossible) writeImp <= 1'b1;
      else if (wrEn && paddr == `OFS_FILE_STATUS && pwdata[`FS_WRITE_IMPOSSIBLE]) writeImp <= 1'b0;
      if (fileEvents.readErr) readErr <= 1'b1;
      else if (wrEn && paddr == `OFS_FILE_STATUS && pwdata[`FS_READ_ERR]) readErr <= 1'b0;
      if (fileEvents.noFile) noFile <= 1'b1;
      else if (wrEn && paddr == `OFS_FILE_STATUS && pwdata[`FS_NO_FILE]) noFile <= 1'b0;
    end
  end

  // A start while busy is refused; starts in one idle cycle all begin, but a self command starts from selfCmdReq, not opStart.cmdSelf
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      opActive <= '0;
      selfCmdAccept <= 1'b0;
      instrErr <= 1'b0;
    end else begin
      selfCmdAccept <= selfOk;
      instrErr <= selfCmdReq && busy;
      opActive.cmdSelf <= (opActive.cmdSelf && !opDone.cmdSelf) || selfOk;
      opActive.readInstr <= (opActive.readInstr && !opDone.readInstr)
                            || (opStart.readInstr && !busy);
      opActive.writeInstr <= (opActive.writeInstr && !opDone.writeInstr)
                             || (opStart.writeInstr && !busy);
      opActive.backup <= (opActive.backup && !opDone.backup) || (opStart.backup && !busy);
    end
  end

  // Transfer count: loaded by software, decremented per word or field
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      itemsLeft <= '0;
    end else if (wrEn && paddr == `OFS_XFER_LOAD) begin
      itemsLeft <= pwdata;
    end else if (itemDone && itemsLeft != '0) begin
      itemsLeft <= itemsLeft - 1'b1;
    end
  end

  // Replacement control words written over APB
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ioMemoryKeepBit <= 1'b0;
      forceHoldBit <= 1'b0;
      password <= '0;
      fileName <= {8{8'h20}};
    end else if (wrEn) begin
      if (paddr == `OFS_REPL_CTRL && pstrb[0]) begin
        ioMemoryKeepBit <= pwdata[`RC_IOM_HOLD];
        forceHoldBit <= pwdata[`RC_FORCE_HOLD];
      end
      if (paddr == `OFS_REPL_PASSWORD) password <= pwdata[15:0];
      if (paddr == `OFS_FILE_NAME_HI) fileName[63:32] <= pwdata;
      if (paddr == `OFS_FILE_NAME_LO) fileName[31:0] <= pwdata;
    end
  end

  // Failure code, priority in checking order
  always_comb begin
    failCode = `CODE_OK;
    if (replCond.fatalErr) failCode = `CODE_FATAL;
    else if (replCond.writeProtected) failCode = `CODE_WRITE_PROT;
    else if (password != `REPL_UNLOCK) failCode = `CODE_BAD_PASSWORD;
    else if (!cardDetected) failCode = `CODE_NO_CARD;
    else if (!replCond.fileFound) failCode = `CODE_NO_FILE;
    else if ((|opActive) || replCond.programWriting || replCond.accessBusy)
      failCode = `CODE_BUSY;
  end

  // Start bit: set by software, cleared by hardware at finish
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      startBit <= 1'b0;
      startPrev <= 1'b0;
    end else begin
      startPrev <= startBit;
      if (state == REPL_RESTART) startBit <= 1'b0;
      else if (wrEn && paddr == `OFS_REPL_CTRL && pstrb[0] && !replActive)
        startBit <= pwdata[`RC_START];
    end
  end

  // Sequencer: armed waits for scan end, load halts execution
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= REPL_IDLE;
      replError <= 1'b0;
      replCode <= `CODE_OK;
      loadCnt <= '0;
    end else begin
      unique case (state)
        REPL_IDLE: begin
          if (startRise) begin
            state <= REPL_ARMED;
            replError <= 1'b0;
          end
        end
        REPL_ARMED: begin
          if (scanEnd) begin
            if (failCode != `CODE_OK) begin
              replError <= 1'b1;
              replCode <= failCode;
              state <= REPL_RESTART;
            end else begin
              state <= REPL_LOAD;
              loadCnt <= `REPL_CYCLES;
            end
          end
        end
        REPL_LOAD: begin
          if (loadCnt != '0) loadCnt <= loadCnt - 1'b1;
          if (replCond.fileTooBig) begin
            replError <= 1'b1;
            replCode <= `CODE_FATAL + 8'h01;
            state <= REPL_RESTART;
          end else if (replCond.loadDone && loadCnt == '0) begin
            replCode <= `CODE_OK;
            state <= REPL_RESTART;
          end
        end
        // Both outcomes pass through here so the start bit is always released
        REPL_RESTART: state <= REPL_IDLE;
      endcase
    end
  end

  // Side effects of replacement toward the CPU core
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      execHalt <= 1'b0;
      watchdogSuspend <= 1'b0;
      intMask <= 1'b0;
      traceStop <= 1'b0;
      condReinit <= 1'b0;
      edgeFlagReinit <= 1'b0;
      timerPvClear <= 1'b0;
      ioMemClear <= 1'b0;
      forceClear <= 1'b0;
      loadReq <= 1'b0;
      tasksRestart <= 1'b0;
      firstScan <= 1'b0;
      firstScanPend <= 1'b0;
    end else begin
      execHalt <= (state == REPL_LOAD);
      watchdogSuspend <= (state == REPL_LOAD);
      intMask <= (state == REPL_LOAD);
      traceStop <= (state == REPL_LOAD);
      condReinit <= (state == REPL_LOAD);
      edgeFlagReinit <= (state == REPL_LOAD);
      timerPvClear <= (state == REPL_LOAD);
      ioMemClear <= (state == REPL_LOAD) && !ioMemoryKeepBit;
      forceClear <= (state == REPL_LOAD) && !forceHoldBit;
      loadReq <= (state == REPL_LOAD);
      tasksRestart <= (state == REPL_RESTART) && !replError;
      // First-scan flag spans the whole first scan after the restart
      if (state == REPL_RESTART && !replError) firstScanPend <= 1'b1;
      else if (firstScan && scanEnd) firstScanPend <= 1'b0;
      if (firstScanPend && !firstScan) firstScan <= 1'b1;
      else if (firstScan && scanEnd) firstScan <= 1'b0;
    end
  end

  // APB read mux; unmapped addresses read zero, with an error above the load offset or when misaligned
  always_comb begin
    next_prdata = '0;
    unique case (paddr)
      `OFS_FILE_STATUS: begin
        next_prdata[`FS_CARD_TYPE_LSB +: CARD_TYPE_W] = cardTypeReg;
        next_prdata[`FS_EM_FMT_ERR] = emFmtErr;
        next_prdata[`FS_CARD_FMT_ERR] = cardFmtErr;
        next_prdata[`FS_WRITE_ERR] = writeErr;
        next_prdata[`FS_WRITE_IMPOSSIBLE] = writeImp;
        next_prdata[`FS_READ_ERR] = readErr;
        next_prdata[`FS_NO_FILE] = noFile;
        next_prdata[`FS_BUSY] = busy;
        next_prdata[`FS_ACCESSING] = accessing;
        next_prdata[`FS_CARD_DETECTED] = cardDetected;
      end
      `OFS_XFER_REMAIN: next_prdata = itemsLeft;
      `OFS_REPL_CTRL: next_prdata = {29'h0, forceHoldBit, ioMemoryKeepBit, startBit};
      `OFS_REPL_STATUS: begin
        next_prdata[`RS_CODE_LSB +: 8] = replCode;
        next_prdata[`RS_ERROR] = replError;
        next_prdata[`RS_START] = startBit;
        next_prdata[`RS_ACTIVE] = replActive;
        next_prdata[`RS_FIRST_SCAN] = firstScan;
      end
      `OFS_REPL_PASSWORD: next_prdata = {16'h0, password};
      `OFS_FILE_NAME_HI: next_prdata = fileName[63:32];
      `OFS_FILE_NAME_LO: next_prdata = fileName[31:0];
      default: next_prdata = '0;
    endcase
  end

  // Read data is captured at setup so it stands through the access cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (rdEn) prdata <= next_prdata;
      pslverr <= psel && !penable && (paddr > `OFS_XFER_LOAD || paddr[1:0] != 2'b00);
    end
  end
endmodule

/* File: program_replace_file_status_assertions.sv */
// Concurrent checks on the ports of the file status and program replacement block
`timescale 1ns/1ns
module program_replace_file_status_checker
  import program_replace_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic selfCmdReq,
  input wire logic scanEnd,
  input wire repl_cond_s replCond,
  input wire logic selfCmdAccept,
  input wire logic instrErr,
  input wire logic execHalt,
  input wire logic watchdogSuspend,
  input wire logic intMask,
  input wire logic traceStop,
  input wire logic condReinit,
  input wire logic edgeFlagReinit,
  input wire logic timerPvClear,
  input wire logic tasksRestart,
  input wire logic firstScan
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_PREADY_ACCESS: assert property (psel && penable |-> pready && !$past(pready))
    else $error("pready missing in access cycle");
  AST_PSLVERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_SELF_ANSWER: assert property (selfCmdReq |=> selfCmdAccept != instrErr)
    else $error("self command not answered once");
  AST_SELF_CAUSE: assert property (selfCmdAccept || instrErr |-> $past(selfCmdReq))
    else $error("self command answer without request");
  AST_REFUSE_IN_LOAD: assert property (execHalt && !replCond.loadDone && selfCmdReq |=> instrErr)
    else $error("self command taken during replacement");
  AST_HALT_GROUP: assert property ({watchdogSuspend, intMask, traceStop, condReinit,
      edgeFlagReinit, timerPvClear} == {6{execHalt}})
    else $error("replacement controls disagree");
  AST_HALT_AT_SCAN_END: assert property ($rose(execHalt) |-> $past(scanEnd) || $past(scanEnd, 2))
    else $error("replacement began away from scan end");
  AST_HALT_MIN_LOAD: assert property ($rose(execHalt) |-> execHalt [*6])
    else $error("replacement load too short");
  AST_RESTART_FIRST: assert property (tasksRestart |=> firstScan && !tasksRestart)
    else $error("first scan flag missing after restart");
  AST_FIRST_HOLD: assert property (firstScan && !scanEnd |=> firstScan)
    else $error("first scan flag dropped mid scan");
  AST_FIRST_END: assert property (firstScan && scanEnd |=> !firstScan)
    else $error("first scan flag outlived its scan");
endmodule
bind program_replace_file_status program_replace_file_status_checker i_chk (.mclk(mclk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .selfCmdReq(selfCmdReq), .scanEnd(scanEnd), .replCond(replCond),
  .selfCmdAccept(selfCmdAccept), .instrErr(instrErr), .execHalt(execHalt),
  .watchdogSuspend(watchdogSuspend), .intMask(intMask), .traceStop(traceStop),
  .condReinit(condReinit), .edgeFlagReinit(edgeFlagReinit), .timerPvClear(timerPvClear),
  .tasksRestart(tasksRestart), .firstScan(firstScan));

/* File: program_replace_file_status_tb.sv */
// Self-checking bench for the file status and program replacement block
`timescale 1ns/1ns
`include "program_replace_regs.svh"
module program_replace_file_status_tb import program_replace_pkg::*;;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] cardType;
  logic cardPresent, selfCmdReq, dataAccess, itemDone, scanEnd;
  file_events_s fileEvents;
  file_ops_s opStart, opDone;
  repl_cond_s replCond;
  logic selfCmdAccept, instrErr, execHalt, watchdogSuspend, intMask, traceStop, condReinit;
  logic edgeFlagReinit, timerPvClear, ioMemClear, forceClear, loadReq, tasksRestart, firstScan;
  int n_errors, compares;
  program_replace_file_status i_program_replace_file_status (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cardType(cardType),
    .cardPresent(cardPresent), .fileEvents(fileEvents), .opStart(opStart), .opDone(opDone),
    .selfCmdReq(selfCmdReq), .dataAccess(dataAccess), .itemDone(itemDone), .scanEnd(scanEnd),
    .replCond(replCond), .selfCmdAccept(selfCmdAccept), .instrErr(instrErr),
    .execHalt(execHalt), .watchdogSuspend(watchdogSuspend), .intMask(intMask),
    .traceStop(traceStop), .condReinit(condReinit), .edgeFlagReinit(edgeFlagReinit),
    .timerPvClear(timerPvClear), .ioMemClear(ioMemClear), .forceClear(forceClear),
    .loadReq(loadReq), .tasksRestart(tasksRestart), .firstScan(firstScan));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Leading edge keeps two transfers from assigning psel in one time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask
  task automatic self_req(input logic [1:0] exp);
    @(posedge mclk);
    selfCmdReq <= 1'b1;
    @(posedge mclk);
    selfCmdReq <= 1'b0;
    @(negedge mclk);
    check({30'h0, selfCmdAccept, instrErr}, {30'h0, exp});
  endtask
  task automatic items(input int n);
    @(posedge mclk);
    itemDone <= 1'b1;
    repeat (n) @(posedge mclk);
    itemDone <= 1'b0;
  endtask
  task automatic run_repl(input logic [31:0] ctrl);
    apb(1'b1, `OFS_REPL_CTRL, ctrl);
    repeat (3) @(posedge mclk);
    check({31'h0, execHalt}, 32'h00000000);
    scanEnd <= 1'b1;
    @(posedge mclk);
    scanEnd <= 1'b0;
  endtask
  task automatic t_basic();
    rdchk(`OFS_FILE_STATUS, 32'h00008002);
    rdchk(`OFS_REPL_STATUS, 32'h00000001);
    rdchk(`OFS_FILE_NAME_HI, 32'h20202020);
    apb(1'b1, `OFS_FILE_NAME_HI, 32'h41424320);
    rdchk(`OFS_FILE_NAME_HI, 32'h41424320);
    rdchk(`OFS_FILE_NAME_LO, 32'h20202020);
    rdchk(12'h020, 32'h00000000);
    check({31'h0, perr}, 32'h00000001);
    cardType <= 3'h5;
    cardPresent <= 1'b0;
    rdchk(`OFS_FILE_STATUS, 32'h00000000);
    cardType <= 3'h2;
    cardPresent <= 1'b1;
    apb(1'b1, `OFS_XFER_LOAD, 32'h80000001);
    items(2);
    rdchk(`OFS_XFER_REMAIN, 32'h7FFFFFFF);
    apb(1'b1, `OFS_XFER_LOAD, 32'h00000001);
    items(3);
    rdchk(`OFS_XFER_REMAIN, 32'h00000000);
    $display("test basic done");
  endtask
  task automatic t_events();
    logic [15:0] exp;
    exp = 16'h8002;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      fileEvents <= file_events_s'(7'h01 << (i == 0 ? 6 : 5 - i));
      @(posedge mclk);
      fileEvents <= '0;
      exp[6 + i] = 1'b1;
      rdchk(`OFS_FILE_STATUS, {16'h0000, exp});
    end
    apb(1'b1, `OFS_FILE_STATUS, 32'h00000F80);
    fileEvents <= file_events_s'(7'h20);
    @(posedge mclk);
    fileEvents <= '0;
    rdchk(`OFS_FILE_STATUS, 32'h00008002);
    $display("test events done");
  endtask
  task automatic t_busy();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      opStart <= file_ops_s'(4'h1 << i);
      @(posedge mclk);
      opStart <= '0;
      if (i == 3) begin
        rdchk(`OFS_FILE_STATUS, 32'h00008002);
        if (!rd[`FS_BUSY]) self_req(2'b10);
      end
      rdchk(`OFS_FILE_STATUS, 32'h0000A002);
      self_req(2'b01);
      opDone <= file_ops_s'(4'h1 << i);
      @(posedge mclk);
      opDone <= '0;
      rdchk(`OFS_FILE_STATUS, 32'h00008002);
    end
    dataAccess <= 1'b1;
    rdchk(`OFS_FILE_STATUS, 32'h00008002);
    opStart <= file_ops_s'(4'h4);
    @(posedge mclk);
    opStart <= '0;
    rdchk(`OFS_FILE_STATUS, 32'h0000E002);
    dataAccess <= 1'b0;
    opDone <= file_ops_s'(4'h4);
    @(posedge mclk);
    opDone <= '0;
    rdchk(`OFS_FILE_STATUS, 32'h00008002);
    $display("test busy done");
  endtask
  task automatic t_fail();
    logic [7:0] codes [6] = '{8'h00, 8'h11, 8'h12, 8'h21, 8'h22, 8'h31};
    int k;
    for (int i = 0; i < 6; i++) begin
      replCond <= '{fatalErr: i == 0, writeProtected: i == 1, fileFound: i != 4, default: 1'b0};
      cardPresent <= i != 3;
      opStart <= {3'b000, i == 5};
      apb(1'b1, `OFS_REPL_PASSWORD, i == 2 ? 32'h00001234 : 32'h0000A5A5);
      opStart <= '0;
      run_repl(32'h00000001);
      k = 0;
      do begin
        apb(1'b0, `OFS_REPL_STATUS, 32'h00000000);
        k++;
      end while (rd[15] && k < 20);
      check(rd, {16'h0000, 8'h40, codes[i]});
      opDone <= {3'b000, i == 5};
      @(posedge mclk);
      opDone <= '0;
    end
    $display("test refusals done");
  endtask
  task automatic t_replace(input logic [31:0] ctrl, input logic [1:0] clr);
    int k;
    replCond <= '{fileFound: 1'b1, default: 1'b0};
    cardPresent <= 1'b1;
    apb(1'b1, `OFS_REPL_PASSWORD, 32'h0000A5A5);
    run_repl(ctrl);
    k = 0;
    while (execHalt !== 1'b1 && k < 10) begin
      @(posedge mclk);
      k++;
    end
    @(negedge mclk);
    check({29'h0, execHalt, ioMemClear, forceClear}, {29'h1, clr});
    self_req(2'b01);
    rdchk(`OFS_FILE_STATUS, 32'h0000A002);
    replCond.loadDone <= 1'b1;
    k = 0;
    while (firstScan !== 1'b1 && k < 40) begin
      @(posedge mclk);
      k++;
    end
    replCond.loadDone <= 1'b0;
    @(negedge mclk);
    check({30'h0, firstScan, execHalt}, 32'h00000002);
    @(posedge mclk);
    scanEnd <= 1'b1;
    @(posedge mclk);
    scanEnd <= 1'b0;
    @(negedge mclk);
    check({31'h0, firstScan}, 32'h00000000);
    rdchk(`OFS_REPL_STATUS, 32'h00000001);
    $display("test replacement done");
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    n_errors = 0;
    compares = 0;
    {rst_n, psel, penable, pwrite, selfCmdReq, dataAccess, itemDone, scanEnd} = '0;
    {paddr, pwdata, fileEvents, opStart, opDone, replCond} = '0;
    pstrb = 4'hF;
    cardType = 3'h2;
    cardPresent = 1'b1;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_basic();
    t_events();
    t_busy();
    t_fail();
    t_replace(32'h00000003, 2'b01);
    t_replace(32'h00000005, 2'b10);
    summarize();
  end
  // About seventy times the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    summarize();
  end
endmodule

/* File: program_replace_pkg.sv */
// Types shared by the file status and program replacement block
package program_replace_pkg;
  typedef enum logic [1:0] {
    REPL_IDLE = 2'b00,
    REPL_ARMED = 2'b01,
    REPL_LOAD = 2'b11,
    REPL_RESTART = 2'b10
  } repl_state_e;
  typedef struct packed {
    logic cmdSelf;
    logic readInstr;
    logic writeInstr;
    logic backup;
  } file_ops_s;
  typedef struct packed {
    logic emFormatErr;
    logic emFormatDone;
    logic cardFormatErr;
    logic writeErr;
    logic writeImpossible;
    logic readErr;
    logic noFile;
  } file_events_s;
  typedef struct packed {
    logic fatalErr;
    logic programWriting;
    logic accessBusy;
    logic fileFound;
    logic fileTooBig;
    logic writeProtected;
    logic loadDone;
  } repl_cond_s;
endpackage

/* File: program_replace_regs.svh */
// Register offsets, field positions and codes for the file status block
`ifndef PROGRAM_REPLACE_REGS_SVH
`define PROGRAM_REPLACE_REGS_SVH
`define OFS_FILE_STATUS 12'h000
`define OFS_XFER_REMAIN 12'h004
`define OFS_REPL_CTRL 12'h008
`define OFS_REPL_STATUS 12'h00C
`define OFS_REPL_PASSWORD 12'h010
`define OFS_FILE_NAME_HI 12'h014
`define OFS_FILE_NAME_LO 12'h018
`define OFS_XFER_LOAD 12'h01C
`define FS_CARD_TYPE_LSB 0
`define FS_EM_FMT_ERR 6
`define FS_CARD_FMT_ERR 7
`define FS_WRITE_ERR 8
`define FS_WRITE_IMPOSSIBLE 9
`define FS_READ_ERR 10
`define FS_NO_FILE 11
`define FS_BUSY 13
`define FS_ACCESSING 14
`define FS_CARD_DETECTED 15
`define RC_START 0
`define RC_IOM_HOLD 1
`define RC_FORCE_HOLD 2
`define RS_CODE_LSB 0
`define RS_ERROR 14
`define RS_START 15
`define RS_ACTIVE 16
`define RS_FIRST_SCAN 17
`define REPL_UNLOCK 16'hA5A5
`define CODE_OK 8'h01
`define CODE_FATAL 8'h00
`define CODE_WRITE_PROT 8'h11
`define CODE_BAD_PASSWORD 8'h12
`define CODE_NO_CARD 8'h21
`define CODE_NO_FILE 8'h22
`define CODE_BUSY 8'h31
`define REPL_CYCLES 8'h08
`endif
